// >>> shared/aroi_pkg.sv
/*
  Shared constants and types for the converter result output port.
  Assumes both ends run on one 25 MHz clock domain with a synchronous reset.
*/
package aroi_pkg;
  // Result word
  localparam int RES_W = 12;
  localparam int BYTE_W = 8;
  localparam int NIB_W = 4;
  // Bit positions
  localparam int MSB_POS = 11;
  localparam int B10_POS = 10;
  localparam int B9_POS = 9;
  localparam int B8_POS = 8;
  localparam int HI_NIB_LSB = 8;
  localparam int LO_NIB_LSB = 4;
  // Clock and conversion timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int CONV_TIME_NS = 8000;
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_CNT_W = 8;
  localparam logic [CONV_CNT_W-1:0] CONV_LAST = CONV_CNT_W'(CONV_CYCLES - 1);
  // Shift clock divider: half period in MCLK cycles
  localparam int SCLK_HALF = 4;
  localparam int DIV_W = 3;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SCLK_HALF - 1);
  // Serial bit counter
  localparam int BIT_CNT_W = 4;
  localparam logic [BIT_CNT_W-1:0] BIT_LAST = 4'hb;
  // Three-level format pin
  typedef enum logic [1:0]
  {
    FMT_PAR12,
    FMT_GATED,
    FMT_FREE
  } aroi_fmt_t;
  localparam logic [NIB_W-1:0] NIB_ZERO = 4'h0;
  localparam logic [RES_W-1:0] RES_ZERO = 12'h000;
endpackage

// >>> shared/aroi_if.sv
/*
  Pins between the converter's output port and its host.
  Assumes the bench resolves each wire from the drive and enable signals.
*/
`timescale 1ns/10ps
interface aroi_if;
  import aroi_pkg::*;
  // Host strobes
  logic rd_n;
  logic cs_n;
  logic conversion_trigger;
  logic upper_byte_select;
  aroi_fmt_t fmt;
  logic ext_clk;
  // Device outputs, enables low while driven
  logic busy_n;
  logic [RES_W-1:0] data_o;
  logic [RES_W-1:0] data_oe_n;
  // Resolved levels as the host sees them
  logic [RES_W-1:0] data_i;
  logic serial_frame_n;
  logic serial_clk;
  logic serial_out;
  modport device (input rd_n, cs_n, conversion_trigger, upper_byte_select, fmt, ext_clk,
    output busy_n, data_o, data_oe_n);
  modport host (output rd_n, cs_n, conversion_trigger, upper_byte_select, fmt, ext_clk,
    input busy_n, data_i, serial_frame_n, serial_clk, serial_out);
endinterface

// >>> verilog/aroi_sync.sv
/*
  Two-flop synchroniser for one pin level.
  Assumes the input is asynchronous to MCLK.
*/
`timescale 1ns/10ps
module aroi_sync
(
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic CE,
  input wire logic d,
  output logic q
);
  logic meta_q;
  // First flop feeds only the second
  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
    begin
      meta_q <= 1'b1;
      q <= 1'b1;
    end
    else if (CE)
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// >>> verilog/aroi_device.sv
/*
  Device end of the converter result port: parallel, byte and framed serial output.
  Assumes the conversion core is outside; a result word arrives on RESULT with its
  conversion. Pins of the host pass through two-flop synchronisers.
*/
// How it works
// - Data driven only with read and select low
// - Active-low busy output flags conversion
// - External clock or internal oscillator times conversion
// - Shared pin: MSB output or byte-select input
// - Byte mode: select picks low or upper byte
// - Format high fixes low lanes to bits
// - Bits 10..8 become frame, clock, data
// - Open-drain low frame marks serial word
// - Shift clock free-running or gated by format
// - Host samples data falling edge, frame low
// - Three-level format pin decode
// - Trigger rise, else select fall, starts conversion
`timescale 1ns/10ps
module aroi_device
(
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic CE,
  aroi_if.device pins,
  input wire logic [aroi_pkg::RES_W-1:0] RESULT,
  input wire logic USE_EXT_CLK,
  output logic CONV_DONE
);
  import aroi_pkg::*;

  typedef enum logic [1:0]
  {
    S_IDLE,
    S_CONV,
    S_SHIFT
  } aroi_dev_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronised host pins
  logic rd_n_s, cs_n_s, trig_s, ubs_s, ext_clk_s;
  aroi_sync u_rd (.MCLK(MCLK), .RESET_N(RESET_N), .CE(CE), .d(pins.rd_n), .q(rd_n_s));
  aroi_sync u_cs (.MCLK(MCLK), .RESET_N(RESET_N), .CE(CE), .d(pins.cs_n), .q(cs_n_s));
  aroi_sync u_tr (.MCLK(MCLK), .RESET_N(RESET_N), .CE(CE),
    .d(pins.conversion_trigger), .q(trig_s));
  aroi_sync u_ub (.MCLK(MCLK), .RESET_N(RESET_N), .CE(CE),
    .d(pins.upper_byte_select), .q(ubs_s));
  aroi_sync u_ck (.MCLK(MCLK), .RESET_N(RESET_N), .CE(CE), .d(pins.ext_clk), .q(ext_clk_s));
  // Format strap; resets to an unused code, so neither mode acts until it settles
  logic [1:0] fmt_s;
  wire [1:0] fmt_pin = pins.fmt;
  aroi_sync u_f0 (.MCLK(MCLK), .RESET_N(RESET_N), .CE(CE), .d(fmt_pin[0]), .q(fmt_s[0]));
  aroi_sync u_f1 (.MCLK(MCLK), .RESET_N(RESET_N), .CE(CE), .d(fmt_pin[1]), .q(fmt_s[1]));

  ////////////////////////////////////////////////////////////////////////////
  // State
  aroi_dev_state_t state_q, state_d;
  logic trig_q, cs_q, eclk_q;
  logic [CONV_CNT_W-1:0] conv_cnt_q;
  logic [RES_W-1:0] result_q, shreg_q;
  logic [DIV_W-1:0] div_q;
  logic [BIT_CNT_W-1:0] bit_q;
  logic sclk_q, frame_q, busy_n_q, done_q;
  logic [RES_W-1:0] data_q, oe_n_q;

  // Format decode
  wire par_mode = (fmt_s == FMT_PAR12);
  wire free_clk = (fmt_s == FMT_FREE);
  // Start sources; trigger held low hands starting to chip select
  wire trig_rise = trig_s & ~trig_q;
  wire cs_fall = ~cs_n_s & cs_q & ~trig_s;
  wire start = (state_q == S_IDLE) & (trig_rise | cs_fall);
  // Conversion time base: an external clock edge, or every cycle internally
  wire ext_edge = ext_clk_s & ~eclk_q;
  wire tick = USE_EXT_CLK ? ext_edge : 1'b1;
  wire conv_end = (state_q == S_CONV) & tick & (conv_cnt_q == CONV_LAST);
  // Shift clock divider, derived from MCLK
  wire div_wrap = (div_q == DIV_LAST);
  wire sclk_fall = div_wrap & sclk_q;
  wire sclk_rise = div_wrap & ~sclk_q;
  wire in_shift = (state_q == S_SHIFT);
  // Frame closes on the rise after the twelfth fall, so that fall is still framed
  wire all_bits = (bit_q > BIT_LAST);
  wire shift_end = in_shift & sclk_rise & all_bits;
  // Read enable
  wire read_en = ~rd_n_s & ~cs_n_s;

  // Next state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      S_IDLE: if (start) state_d = S_CONV;
      S_CONV: if (conv_end) state_d = par_mode ? S_IDLE : S_SHIFT;
      S_SHIFT: if (shift_end) state_d = S_IDLE;
      default: state_d = S_IDLE;
    endcase
  end

  // Output lane mux
  wire [RES_W-1:0] word = result_q;
  wire [BYTE_W-1:0] upper_lane = {NIB_ZERO, word[MSB_POS:HI_NIB_LSB]};
  wire [BYTE_W-1:0] low_lane = (ubs_s & ~par_mode) ? upper_lane : word[BYTE_W-1:0];
  wire [RES_W-1:0] data_d = par_mode ? word : {NIB_ZERO, low_lane};
  // Shared pins: data bits 11..8 driven only in parallel mode
  wire [NIB_W-1:0] hi_oe_n = par_mode ? {NIB_W{~read_en}} : {NIB_W{1'b1}};
  wire [RES_W-1:0] oe_n_d = {hi_oe_n, {BYTE_W{~read_en}}};

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
    begin
      state_q <= S_IDLE;
      // Edge detectors match the synchronisers' reset level: no false edge at release
      trig_q <= 1'b1;
      cs_q <= 1'b1;
      eclk_q <= 1'b1;
      busy_n_q <= 1'b1;
      done_q <= 1'b0;
      conv_cnt_q <= '0;
    end
    else if (CE)
    begin
      state_q <= state_d;
      trig_q <= trig_s;
      cs_q <= cs_n_s;
      eclk_q <= ext_clk_s;
      busy_n_q <= ~(state_d == S_CONV);
      done_q <= conv_end;
      if (start)
        conv_cnt_q <= '0;
      else if (state_q == S_CONV && tick)
        conv_cnt_q <= conv_cnt_q + 1'b1;
    end
  end

  // Result and data lane registers
  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
    begin
      result_q <= RES_ZERO;
      data_q <= RES_ZERO;
      oe_n_q <= '1;
    end
    else if (CE)
    begin
      if (conv_end)
        result_q <= RESULT;
      data_q <= data_d;
      oe_n_q <= oe_n_d;
    end
  end

  // Serial engine: frame low across twelve falling edges
  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
    begin
      div_q <= '0;
      sclk_q <= 1'b1;
      bit_q <= '0;
      frame_q <= 1'b1;
      shreg_q <= RES_ZERO;
    end
    else if (CE)
    begin
      div_q <= div_wrap ? '0 : div_q + 1'b1;
      // Gated mode parks the clock high between frames
      if (div_wrap)
        sclk_q <= (free_clk || state_q == S_SHIFT) ? ~sclk_q : 1'b1;
      // Falls are counted; data moves on the next rise, never under a fall
      if (conv_end && !par_mode)
      begin
        shreg_q <= RESULT;
        frame_q <= 1'b0;
        bit_q <= '0;
      end
      else if (shift_end)
        frame_q <= 1'b1;
      else if (in_shift && sclk_fall)
        bit_q <= bit_q + 1'b1;
      else if (in_shift && sclk_rise && bit_q != '0)
        shreg_q <= {shreg_q[RES_W-2:0], 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins: serial lines open-drain, enable low means pulling low
  logic so_q, sck_oe_q, fr_oe_q;
  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
    begin
      so_q <= 1'b1;
      sck_oe_q <= 1'b1;
      fr_oe_q <= 1'b1;
    end
    else if (CE)
    begin
      so_q <= ~(~par_mode & ~frame_q & ~shreg_q[MSB_POS]);
      sck_oe_q <= par_mode | sclk_q;
      fr_oe_q <= par_mode | frame_q;
    end
  end

  // Serial functions share bits 10..8 outside parallel mode
  assign pins.data_o = par_mode ? data_q : {1'b0, 3'h0, data_q[BYTE_W-1:0]};
  assign pins.data_oe_n = par_mode ? oe_n_q : {1'b1, fr_oe_q, sck_oe_q, so_q,
    oe_n_q[BYTE_W-1:0]};
  assign pins.busy_n = busy_n_q;
  assign CONV_DONE = done_q;
endmodule

// >>> verilog/aroi_host.sv
/*
  Host end: starts conversions, reads words or bytes, and receives serial words.
  Assumes one MCLK domain; busy and serial pins pass two-flop synchronisers, data lanes are sampled directly.
*/
`timescale 1ns/10ps
module aroi_host
(
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic CE,
  aroi_if.host pins,
  input wire logic START,
  input wire logic READ_REQ,
  input wire logic UPPER,
  input wire logic [1:0] FMT_SEL,
  output logic [aroi_pkg::RES_W-1:0] RD_DATA,
  output logic RD_VALID,
  output logic [aroi_pkg::RES_W-1:0] SER_DATA,
  output logic SER_VALID
);
  import aroi_pkg::*;

  logic busy_s, fr_s, sck_s, sd_s;
  aroi_sync u_b (.MCLK(MCLK), .RESET_N(RESET_N), .CE(CE), .d(pins.busy_n), .q(busy_s));
  aroi_sync u_f (.MCLK(MCLK), .RESET_N(RESET_N), .CE(CE), .d(pins.serial_frame_n), .q(fr_s));
  aroi_sync u_c (.MCLK(MCLK), .RESET_N(RESET_N), .CE(CE), .d(pins.serial_clk), .q(sck_s));
  aroi_sync u_d (.MCLK(MCLK), .RESET_N(RESET_N), .CE(CE), .d(pins.serial_out), .q(sd_s));

  logic trig_q, rd_n_q, ub_q, sck_q, fr_q, rdv_q, serv_q;
  logic [1:0] rd_cnt_q;
  logic [RES_W-1:0] rdd_q, sr_q, serd_q;
  logic [DIV_W-1:0] ediv_q;
  logic eclk_q;
  aroi_fmt_t fmt_q;
  // Sample on falling shift clock only inside the frame; a fall that opens it is ignored
  wire sck_fall = sck_q & ~sck_s & ~fr_s & ~fr_q;
  wire fr_end = ~fr_q & fr_s;

  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
    begin
      trig_q <= 1'b0;
      rd_n_q <= 1'b1;
      ub_q <= 1'b0;
      sck_q <= 1'b1;
      fr_q <= 1'b1;
      rd_cnt_q <= 2'h0;
      rdd_q <= RES_ZERO;
      rdv_q <= 1'b0;
      sr_q <= RES_ZERO;
      serd_q <= RES_ZERO;
      serv_q <= 1'b0;
      ediv_q <= '0;
      eclk_q <= 1'b0;
      fmt_q <= FMT_PAR12;
    end
    else if (CE)
    begin
      trig_q <= START;
      ub_q <= UPPER;
      fmt_q <= aroi_fmt_t'(FMT_SEL);
      // External conversion clock, eight MCLK cycles a period; slower than internal
      ediv_q <= (ediv_q == DIV_LAST) ? '0 : ediv_q + 1'b1;
      if (ediv_q == DIV_LAST)
        eclk_q <= ~eclk_q;
      sck_q <= sck_s;
      fr_q <= fr_s;
      rdv_q <= 1'b0;
      serv_q <= 1'b0;
      // Read held long enough to cover the device's synchroniser
      if (READ_REQ && rd_n_q)
      begin
        rd_n_q <= 1'b0;
        rd_cnt_q <= 2'h3;
      end
      else if (!rd_n_q)
      begin
        rd_cnt_q <= rd_cnt_q - 2'h1;
        if (rd_cnt_q == 2'h0)
        begin
          rd_n_q <= 1'b1;
          rdd_q <= pins.data_i;
          rdv_q <= 1'b1;
        end
      end
      if (sck_fall)
        sr_q <= {sr_q[RES_W-2:0], sd_s};
      if (fr_end)
      begin
        serd_q <= sr_q;
        serv_q <= 1'b1;
      end
    end
  end

  assign pins.rd_n = rd_n_q;
  assign pins.cs_n = rd_n_q;
  assign pins.conversion_trigger = trig_q;
  assign pins.upper_byte_select = ub_q;
  assign pins.fmt = fmt_q;
  assign pins.ext_clk = eclk_q;
  assign RD_DATA = rdd_q;
  assign RD_VALID = rdv_q;
  assign SER_DATA = serd_q;
  assign SER_VALID = serv_q;
endmodule

// >>> verif/aroi_chk.sv
/* Assertions on the wires between the two ends of the result port.
   Assumes one MCLK domain and serial pins resolved by the bench. */
`timescale 1ns/10ps
module aroi_chk
(
  input logic MCLK,
  input logic RESET_N,
  input logic rd_n,
  input logic cs_n,
  input logic conversion_trigger,
  input logic upper_byte_select,
  input aroi_pkg::aroi_fmt_t fmt,
  input logic busy_n,
  input logic [aroi_pkg::RES_W-1:0] data_o,
  input logic [aroi_pkg::RES_W-1:0] data_oe_n,
  input logic serial_frame_n,
  input logic serial_clk
);
  import aroi_pkg::*;
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RESET_N);
  ////////////////////////////////////////
  // Clock falls since the frame opened; edge counted with the frame end
  logic clk_q;
  logic frm_q;
  logic [4:0] falls_q;
  logic [4:0] falls_d;
  assign falls_d = (frm_q & ~serial_frame_n) ? 5'h00 : falls_q + {4'h0, clk_q & ~serial_clk};
  always_ff @(posedge MCLK)
  begin
    clk_q <= serial_clk;
    frm_q <= serial_frame_n;
    falls_q <= falls_d;
  end
  ////////////////////////////////////////
  a_lanes_released:
    assert property ((rd_n | cs_n) [*6] |-> &data_oe_n[7:0]) else $error("lanes driven idle");
  a_lanes_driven:
    assert property ($fell(rd_n) && !cs_n |-> ##[1:6] data_oe_n[7:0] == 8'h00)
    else $error("read not driven");
  a_upper_zero:
    assert property ((fmt != FMT_PAR12 && upper_byte_select) [*4] ##0 data_oe_n[7:0] == 8'h00
      |-> data_o[7:4] == NIB_ZERO) else $error("upper byte not zero filled");
  a_parallel_upper:
    assert property ((fmt == FMT_PAR12) [*4] ##0 data_oe_n[7:0] == 8'h00
      |-> data_oe_n[11:8] == 4'h0) else $error("upper bits not driven");
  a_msb_input:
    assert property ((fmt != FMT_PAR12) [*4] |-> data_oe_n[11]) else $error("select pin driven");
  a_busy_holds:
    assert property ($fell(busy_n) |-> !busy_n [*8]) else $error("busy too short");
  a_trigger_start:
    assert property ($rose(conversion_trigger) && busy_n && serial_frame_n && rd_n
      |-> ##[2:6] !busy_n) else $error("trigger did not start");
  a_twelve_falls:
    assert property (!frm_q && serial_frame_n && fmt != FMT_PAR12 |-> falls_d == 5'h0c)
    else $error("frame clock count");
  a_gated_parks:
    assert property ((fmt == FMT_GATED && serial_frame_n) [*8] |-> serial_clk)
    else $error("gated clock runs");
  a_free_runs:
    assert property ((fmt == FMT_FREE) [*8] ##0 serial_clk |-> ##[1:5] !serial_clk)
    else $error("free clock stopped");
  // Main traffic seen
  c_gated: cover property ($rose(serial_frame_n) && fmt == FMT_GATED);
  c_free: cover property ($rose(serial_frame_n) && fmt == FMT_FREE);
  c_upper: cover property (upper_byte_select && data_oe_n[7:0] == 8'h00);
endmodule

// >>> verif/testbench.sv
/* Self-checking bench joining host and device ends of the result port.
   Assumes pull-ups on the open-drain serial lines; other released lanes read back the inverse of data_o. */
`timescale 1ns/10ps
module testbench;
  import aroi_pkg::*;
  typedef struct {logic [1:0] fmt; logic ubs; logic [11:0] res;
    logic [11:0] exp; logic [11:0] msk;} aroi_row_t;
  localparam logic [11:0] PULL = 12'h700;
  logic mclk = 0;
  logic reset_n = 0;
  logic start = 0;
  logic read_req = 0;
  logic upper = 0;
  logic use_ext = 0;
  logic [1:0] fmt_sel = 2'h0;
  logic [11:0] result = 12'h000;
  logic [11:0] rd_data;
  logic [11:0] ser_data;
  logic rd_valid;
  logic ser_valid;
  logic conv_done;
  int errors = 0;
  int cmp_count = 0;
  int n;
  // Byte reads cover both selects, serial rows cover both clock modes
  aroi_row_t rows [6] = '{
    '{2'h0, 1'b0, 12'ha5c, 12'ha5c, 12'hfff},
    '{2'h0, 1'b1, 12'h3c9, 12'h3c9, 12'hfff},
    '{2'h1, 1'b0, 12'h8e1, 12'h0e1, 12'h0ff},
    '{2'h1, 1'b1, 12'h8e1, 12'h008, 12'h0ff},
    '{2'h2, 1'b1, 12'hfff, 12'h00f, 12'h0ff},
    '{2'h2, 1'b0, 12'h001, 12'h001, 12'h0ff}};
  ////////////////////////////////////////
  aroi_if aroi_if_inst ();
  wire [11:0] oe_n = aroi_if_inst.data_oe_n;
  wire [11:0] dout = aroi_if_inst.data_o;
  // Released lanes outside pulled-up bits 10..8 show the inverse, so a stale value never passes
  wire [11:0] drv = (aroi_if_inst.fmt != FMT_PAR12) ? (dout & ~PULL) : dout;
  assign aroi_if_inst.data_i = (drv & ~oe_n) | (oe_n & (PULL | ~dout));
  assign aroi_if_inst.serial_frame_n = aroi_if_inst.data_i[10];
  assign aroi_if_inst.serial_clk = aroi_if_inst.data_i[9];
  assign aroi_if_inst.serial_out = aroi_if_inst.data_i[8];
  aroi_device aroi_device_inst (.MCLK(mclk), .RESET_N(reset_n), .CE(1'b1),
    .pins(aroi_if_inst.device), .RESULT(result), .USE_EXT_CLK(use_ext), .CONV_DONE(conv_done));
  aroi_host aroi_host_inst (.MCLK(mclk), .RESET_N(reset_n), .CE(1'b1),
    .pins(aroi_if_inst.host), .START(start), .READ_REQ(read_req), .UPPER(upper),
    .FMT_SEL(fmt_sel), .RD_DATA(rd_data), .RD_VALID(rd_valid), .SER_DATA(ser_data),
    .SER_VALID(ser_valid));
  aroi_chk aroi_chk_inst (.MCLK(mclk), .RESET_N(reset_n), .rd_n(aroi_if_inst.rd_n),
    .cs_n(aroi_if_inst.cs_n), .conversion_trigger(aroi_if_inst.conversion_trigger),
    .upper_byte_select(aroi_if_inst.upper_byte_select), .fmt(aroi_if_inst.fmt),
    .busy_n(aroi_if_inst.busy_n), .data_o(dout), .data_oe_n(oe_n),
    .serial_frame_n(aroi_if_inst.serial_frame_n), .serial_clk(aroi_if_inst.serial_clk));
  ////////////////////////////////////////
  task automatic finish_test;
    if (errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic [11:0] got, input logic [11:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
      errors++;
    end
  endtask
  // Bounded wait for a pulse; must=0 means the pulse is not allowed
  task automatic wait_for(input int sel, input int bound, input bit must, output int cnt);
    bit hit;
    hit = 0;
    cnt = 0;
    while (!hit && cnt < bound)
    begin
      @(negedge mclk);
      cnt++;
      hit = sel == 0 ? conv_done === 1'b1 : sel == 1 ? ser_valid === 1'b1 : rd_valid === 1'b1;
    end
    if (hit != must)
    begin
      $display("[FAIL] %0t wait on pulse %0d", $time, sel);
      errors++;
      if (must)
        finish_test();
    end
  endtask
  task automatic do_read;
    read_req = 1;
    @(negedge mclk);
    read_req = 0;
    wait_for(2, 20, 1, n);
  endtask
  task automatic do_reset;
    @(negedge mclk);
    reset_n = 0;
    start = 0;
    repeat (6) @(negedge mclk);
    check(aroi_if_inst.busy_n, 12'h1, "busy in reset");
    check(oe_n, 12'hfff, "lanes in reset");
    check(conv_done, 12'h0, "done in reset");
    reset_n = 1;
    repeat (4) @(negedge mclk);
  endtask
  ////////////////////////////////////////
  initial
  begin
    forever #20 mclk = ~mclk;
  end
  initial
  begin
    do_reset();
    foreach (rows[i])
    begin
      fmt_sel = rows[i].fmt;
      upper = rows[i].ubs;
      result = rows[i].res;
      repeat (8) @(negedge mclk);
      start = 1;
      wait_for(0, 400, 1, n);
      check(12'(n >= 201 && n <= 208), 12'h1, "conversion time");
      if (rows[i].fmt != 2'h0)
      begin
        wait_for(1, 200, 1, n);
        check(ser_data, rows[i].res, "serial word");
      end
      do_read();
      check(rd_data & rows[i].msk, rows[i].exp, "read word");
      start = 0;
      repeat (4) @(negedge mclk);
    end
    // Retrigger while busy must not start a second conversion
    start = 1;
    repeat (20) @(negedge mclk);
    start = 0;
    @(negedge mclk);
    start = 1;
    wait_for(0, 400, 1, n);
    wait_for(0, 300, 0, n);
    start = 0;
    fmt_sel = 2'h0;
    repeat (8) @(negedge mclk);
    // Select falling with trigger low starts a conversion
    do_read();
    wait_for(0, 400, 1, n);
    // External clock is slower than the internal one
    use_ext = 1;
    repeat (4) @(negedge mclk);
    start = 1;
    wait_for(0, 5000, 1, n);
    check(12'(n > 300), 12'h1, "external clock");
    start = 0;
    use_ext = 0;
    repeat (4) @(negedge mclk);
    // Reset in mid conversion, then a clean one
    start = 1;
    repeat (50) @(negedge mclk);
    do_reset();
    start = 1;
    wait_for(0, 400, 1, n);
    check(12'(n >= 201 && n <= 208), 12'h1, "after reset");
    finish_test();
  end
endmodule
